//--- logic/tdac_pkg.sv
// Shared constants and types for the temperature-driven dual DAC mode control
package tdac_pkg;

    localparam int WORD_W = 12;
    localparam int BYTE_W = 8;
    localparam int NIB_W = 4;
    localparam int CHAN_N = 2;
    localparam int LUT_ADDR_W = 4;
    localparam int LUT_DEPTH = 16;

    // Sampling period: figure in ms, count derived from the clock rate
    localparam longint CLK_HZ = 100000000;
    localparam longint SAMPLE_PERIOD_MS = 25;
    localparam longint MS_PER_S = 1000;
    localparam int SAMPLE_CYCLES = int'(SAMPLE_PERIOD_MS * CLK_HZ / MS_PER_S);

    // Register map
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'h00;
    localparam logic [7:0] ADDR_RESULT_LOW = 8'h01;
    localparam logic [7:0] ADDR_CHAN0_HIGH = 8'h02;
    localparam logic [7:0] ADDR_CHAN0_LOW = 8'h03;
    localparam logic [7:0] ADDR_CHAN1_HIGH = 8'h04;
    localparam logic [7:0] ADDR_CHAN1_LOW = 8'h05;
    localparam logic [7:0] ADDR_SENSOR_STATUS = 8'h07;
    localparam logic [7:0] ADDR_OVERRIDE_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_ACCESS_LEVEL = 8'h09;
    localparam logic [7:0] ADDR_SENSOR_OVR_HIGH = 8'h0a;
    localparam logic [7:0] ADDR_SENSOR_OVR_LOW = 8'h0b;
    localparam logic [7:0] ADDR_CHAN0_OVR_HIGH = 8'h0c;
    localparam logic [7:0] ADDR_CHAN0_OVR_LOW = 8'h0d;
    localparam logic [7:0] ADDR_CHAN1_OVR_HIGH = 8'h0e;
    localparam logic [7:0] ADDR_CHAN1_OVR_LOW = 8'h0f;

    // Field positions and codes
    localparam int CTL_SENSOR_BIT = 0;
    localparam int CTL_INPUT_BIT = 1;
    localparam logic [7:0] PASSWORD_FIRST = 8'hcd;
    localparam logic [7:0] PASSWORD_SECOND = 8'hf0;
    localparam logic [7:0] ACCESS_READ_L2 = 8'h03;
    localparam logic [7:0] ACCESS_READ_NONE = 8'h00;
    localparam logic [7:0] STATUS_READY = 8'h00;
    localparam logic [7:0] STATUS_NOT_READY = 8'hff;
    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam logic [11:0] WORD_RESET = 12'h000;
    localparam logic [3:0] NIB_RESET = 4'h0;
    localparam logic [1:0] CTL_RESET = 2'h0;

    typedef logic [WORD_W-1:0] tdac_word_t;

    typedef struct packed {
        tdac_word_t ch1;
        tdac_word_t ch0;
    } tdac_pair_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tdac_regreq_s;

    typedef enum logic [1:0] {
        RC_IDLE = 2'b00,
        RC_FETCH = 2'b01,
        RC_APPLY = 2'b10
    } tdac_state_e;

endpackage : tdac_pkg

//--- logic/tdac_lut_mem.sv
// Coefficient lookup memory with registered read data
module tdac_lut_mem
    import tdac_pkg::*;
#(
    parameter int DATA_W = 2 * WORD_W,
    parameter int DEPTH = LUT_DEPTH,
    parameter int ADDR_W = LUT_ADDR_W
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [DATA_W-1:0] rd_data
);

    logic [DATA_W-1:0] mem [DEPTH];

    // Array carries no reset so it maps onto plain storage
    always_ff @(posedge sys_clk) begin
        if (ce && wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= '0;
        end else if (ce && rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule // tdac_lut_mem

//--- logic/tdac_mode_ctrl.sv
// Signal path mode control: sampling, lookup, bypass, overrides and register file
// Notes on behaviour
// - After reset both override enables are clear and the default path runs.
// - The sensor result is refreshed every 25 ms with no host action.
// - Each new sample starts a recalculation from the lookup coefficients.
// - Each result is written to the channel input registers driving the outputs.
// - Sensor override enable makes the stored override word index the table.
// - The sensor override word is twelve-bit two's complement.
// - A sensor override high write waits; both bytes commit on the low write.
// - Per channel, input override high waits; both bytes commit on low write.
// - Clearing sensor override enable returns the index to the live sample.
// - Sensor override data and control registers are volatile and cleared at reset.
// - Without input override, a set bypass bit sends that channel's base value to its output.
// - Bypass bits are copied from non-volatile storage and act right after reset.
// - Each channel has its own bypass bit and base value.
// - Input override enable routes each channel's override word to its output.
// - One input override enable switches both channels together.
// - Writing 0xcd then 0xf0 to the access register grants level two.
// - Access register reads 0x03 while level two is active.
// - Control value 0x01 enables sensor override, 0x02 enables input override.
// - Result reads return the real sample even under sensor override.
// - Channel input reads return computed values even under input override.
module tdac_mode_ctrl
    import tdac_pkg::*;
#(
    parameter int SAMPLE_TICKS = SAMPLE_CYCLES
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire tdac_word_t sensor_sample,
    input wire logic [CHAN_N-1:0] nv_arith_bypass,
    input wire tdac_pair_s nv_chan_base,
    input wire logic lut_wr_en,
    input wire logic [LUT_ADDR_W-1:0] lut_wr_addr,
    input wire tdac_pair_s lut_wr_data,
    input wire tdac_regreq_s reg_req,
    output logic [BYTE_W-1:0] reg_rdata,
    output tdac_pair_s chan_analog_output,
    output logic level_two_access
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Two's complement to an ordered table index: flip the sign bit
    function automatic logic [LUT_ADDR_W-1:0] to_index(tdac_word_t t);
        to_index = {~t[WORD_W-1], t[WORD_W-2:WORD_W-LUT_ADDR_W]};
    endfunction

    function automatic logic wr_hit(tdac_regreq_s r, logic [7:0] a);
        wr_hit = r.wr && (r.addr == a);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    localparam int CNT_W = $clog2(SAMPLE_TICKS + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SAMPLE_TICKS - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;

    logic [CNT_W-1:0] sample_cnt_reg;
    logic sample_tick;
    logic sample_seen_reg;
    tdac_word_t sensor_result_reg;
    logic [BYTE_W-1:0] result_low_shadow_reg;
    logic [1:0] override_control_reg;
    logic sensor_override_enable;
    logic input_override_enable;
    logic [NIB_W-1:0] sensor_ovr_high_pend_reg;
    tdac_word_t sensor_ovr_reg;
    logic [NIB_W-1:0] chan_ovr_high_pend_reg [CHAN_N];
    tdac_pair_s chan_ovr_reg;
    logic pw_armed_reg;
    logic level_two_reg;
    logic init_done_reg;
    logic [CHAN_N-1:0] arith_bypass_reg;
    tdac_pair_s chan_base_reg;
    tdac_state_e state_reg;
    tdac_state_e state_next;
    logic recalc_pend_reg;
    logic recalc_req;
    logic lut_rd_en;
    logic [LUT_ADDR_W-1:0] lut_addr;
    tdac_pair_s lut_rd_data;
    tdac_pair_s alu_result_reg;
    tdac_pair_s chan_input_reg;
    tdac_pair_s dac_code_reg;
    logic [BYTE_W-1:0] rdata_reg;
    logic [BYTE_W-1:0] rdata_next;
    tdac_word_t index_word;
    logic ovr_commit;

    assign sensor_override_enable = override_control_reg[CTL_SENSOR_BIT];
    assign input_override_enable = override_control_reg[CTL_INPUT_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Sampling

    assign sample_tick = ce && (sample_cnt_reg == CNT_LAST);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sample_cnt_reg <= CNT_ZERO;
        end else if (ce) begin
            sample_cnt_reg <= (sample_cnt_reg == CNT_LAST) ? CNT_ZERO : sample_cnt_reg + 1'b1;
        end
    end

    // Result keeps the real sample whatever the override state
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sensor_result_reg <= WORD_RESET;
            sample_seen_reg <= 1'b0;
        end else if (sample_tick) begin
            sensor_result_reg <= sensor_sample;
            sample_seen_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Access level

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pw_armed_reg <= 1'b0;
            level_two_reg <= 1'b0;
        end else if (ce && wr_hit(reg_req, ADDR_ACCESS_LEVEL)) begin
            pw_armed_reg <= (reg_req.wdata == PASSWORD_FIRST);
            // Any other value drops the level, so a stray write locks the overrides again
            level_two_reg <= pw_armed_reg && (reg_req.wdata == PASSWORD_SECOND);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Override registers (volatile)

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            override_control_reg <= CTL_RESET;
        end else if (ce && level_two_reg && wr_hit(reg_req, ADDR_OVERRIDE_CONTROL)) begin
            // Both bits stored as written; host keeps them exclusive
            override_control_reg <= reg_req.wdata[CTL_INPUT_BIT:CTL_SENSOR_BIT];
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sensor_ovr_high_pend_reg <= NIB_RESET;
            sensor_ovr_reg <= WORD_RESET;
        end else if (ce && level_two_reg) begin
            if (wr_hit(reg_req, ADDR_SENSOR_OVR_HIGH)) begin
                sensor_ovr_high_pend_reg <= reg_req.wdata[NIB_W-1:0];
            end
            if (wr_hit(reg_req, ADDR_SENSOR_OVR_LOW)) begin
                sensor_ovr_reg <= {sensor_ovr_high_pend_reg, reg_req.wdata};
            end
        end
    end

    generate
        for (genvar c = 0; c < CHAN_N; c++) begin : g_chan_ovr
            localparam logic [7:0] A_HIGH = (c == 0) ? ADDR_CHAN0_OVR_HIGH : ADDR_CHAN1_OVR_HIGH;
            localparam logic [7:0] A_LOW = (c == 0) ? ADDR_CHAN0_OVR_LOW : ADDR_CHAN1_OVR_LOW;
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    chan_ovr_high_pend_reg[c] <= NIB_RESET;
                    chan_ovr_reg[c*WORD_W +: WORD_W] <= WORD_RESET;
                end else if (ce && level_two_reg) begin
                    if (wr_hit(reg_req, A_HIGH)) begin
                        chan_ovr_high_pend_reg[c] <= reg_req.wdata[NIB_W-1:0];
                    end
                    if (wr_hit(reg_req, A_LOW)) begin
                        chan_ovr_reg[c*WORD_W +: WORD_W] <= {chan_ovr_high_pend_reg[c], reg_req.wdata};
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Non-volatile bypass and base, caught on the first enabled cycle after reset

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            init_done_reg <= 1'b0;
            arith_bypass_reg <= '0;
            chan_base_reg <= '0;
        end else if (ce && !init_done_reg) begin
            init_done_reg <= 1'b1;
            arith_bypass_reg <= nv_arith_bypass;
            chan_base_reg <= nv_chan_base;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Recalculation

    // The word stored at this edge is forwarded, so a start never reads the previous sample
    assign index_word = sensor_override_enable
        ? (ovr_commit ? {sensor_ovr_high_pend_reg, reg_req.wdata} : sensor_ovr_reg)
        : (sample_tick ? sensor_sample : sensor_result_reg);
    assign lut_addr = to_index(index_word);
    assign ovr_commit = ce && level_two_reg && sensor_override_enable && wr_hit(reg_req, ADDR_SENSOR_OVR_LOW);
    assign recalc_req = sample_tick || ovr_commit || recalc_pend_reg;
    assign lut_rd_en = (state_reg == RC_IDLE) && recalc_req;

    // Start that arrives while busy is held until idle; in idle the clear wins, as that start is taken at once
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            recalc_pend_reg <= 1'b0;
        end else if (ce) begin
            recalc_pend_reg <= (sample_tick || ovr_commit || recalc_pend_reg) && (state_reg != RC_IDLE);
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            RC_IDLE: begin
                if (recalc_req) begin
                    state_next = RC_FETCH;
                end
            end
            RC_FETCH: begin
                state_next = RC_APPLY;
            end
            RC_APPLY: begin
                state_next = RC_IDLE;
            end
            default: begin
                state_next = RC_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= RC_IDLE;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    tdac_lut_mem #(
        .DATA_W(2 * WORD_W),
        .DEPTH(LUT_DEPTH),
        .ADDR_W(LUT_ADDR_W)
    ) u_lut (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .ce(ce),
        .wr_en(lut_wr_en),
        .wr_addr(lut_wr_addr),
        .wr_data(lut_wr_data),
        .rd_en(lut_rd_en),
        .rd_addr(lut_addr),
        .rd_data(lut_rd_data)
    );

    // Arithmetic: base plus per-segment table offset, wrapping at twelve bits
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            alu_result_reg <= '0;
        end else if (ce && state_reg == RC_FETCH) begin
            alu_result_reg.ch0 <= WORD_W'(chan_base_reg.ch0 + lut_rd_data.ch0);
            alu_result_reg.ch1 <= WORD_W'(chan_base_reg.ch1 + lut_rd_data.ch1);
        end
    end

    // Channel input registers hold computed values, never the override words
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            chan_input_reg <= '0;
        end else if (ce && state_reg == RC_APPLY) begin
            chan_input_reg <= alu_result_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output multiplexers

    generate
        for (genvar c = 0; c < CHAN_N; c++) begin : g_out
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    dac_code_reg[c*WORD_W +: WORD_W] <= WORD_RESET;
                end else if (ce) begin
                    if (input_override_enable) begin
                        dac_code_reg[c*WORD_W +: WORD_W] <= chan_ovr_reg[c*WORD_W +: WORD_W];
                    end else if (arith_bypass_reg[c]) begin
                        dac_code_reg[c*WORD_W +: WORD_W] <= chan_base_reg[c*WORD_W +: WORD_W];
                    end else begin
                        dac_code_reg[c*WORD_W +: WORD_W] <= chan_input_reg[c*WORD_W +: WORD_W];
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Register reads

    always_comb begin
        rdata_next = READ_ZERO;
        case (reg_req.addr)
            ADDR_RESULT_HIGH: rdata_next = BYTE_W'(sensor_result_reg[WORD_W-1:BYTE_W]);
            ADDR_RESULT_LOW: rdata_next = result_low_shadow_reg;
            ADDR_CHAN0_HIGH: rdata_next = BYTE_W'(chan_input_reg.ch0[WORD_W-1:BYTE_W]);
            ADDR_CHAN0_LOW: rdata_next = chan_input_reg.ch0[BYTE_W-1:0];
            ADDR_CHAN1_HIGH: rdata_next = BYTE_W'(chan_input_reg.ch1[WORD_W-1:BYTE_W]);
            ADDR_CHAN1_LOW: rdata_next = chan_input_reg.ch1[BYTE_W-1:0];
            ADDR_SENSOR_STATUS: rdata_next = sample_seen_reg ? STATUS_READY : STATUS_NOT_READY;
            ADDR_OVERRIDE_CONTROL: rdata_next = BYTE_W'(override_control_reg);
            ADDR_ACCESS_LEVEL: rdata_next = level_two_reg ? ACCESS_READ_L2 : ACCESS_READ_NONE;
            ADDR_SENSOR_OVR_HIGH: rdata_next = BYTE_W'(sensor_ovr_reg[WORD_W-1:BYTE_W]);
            ADDR_SENSOR_OVR_LOW: rdata_next = sensor_ovr_reg[BYTE_W-1:0];
            ADDR_CHAN0_OVR_HIGH: rdata_next = BYTE_W'(chan_ovr_reg.ch0[WORD_W-1:BYTE_W]);
            ADDR_CHAN0_OVR_LOW: rdata_next = chan_ovr_reg.ch0[BYTE_W-1:0];
            ADDR_CHAN1_OVR_HIGH: rdata_next = BYTE_W'(chan_ovr_reg.ch1[WORD_W-1:BYTE_W]);
            ADDR_CHAN1_OVR_LOW: rdata_next = chan_ovr_reg.ch1[BYTE_W-1:0];
            default: rdata_next = READ_ZERO;
        endcase
    end

    // Low byte is frozen by the high read so a pair read stays coherent
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            result_low_shadow_reg <= READ_ZERO;
        end else if (ce && reg_req.rd && reg_req.addr == ADDR_RESULT_HIGH) begin
            result_low_shadow_reg <= sensor_result_reg[BYTE_W-1:0];
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg <= READ_ZERO;
        end else if (ce && reg_req.rd) begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign chan_analog_output = dac_code_reg;
    assign level_two_access = level_two_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    chk_power_defaults: assert property (!init_done_reg |-> override_control_reg == CTL_RESET && sensor_ovr_reg == WORD_RESET)
        else $error("override state not clear after reset");
    chk_sample_capture: assert property (sample_tick |=> sensor_result_reg == $past(sensor_sample))
        else $error("sample not captured on tick");
    chk_recalc_start: assert property (ce && sample_tick && state_reg == RC_IDLE |=> state_reg == RC_FETCH)
        else $error("new sample did not start recalculation");
    chk_input_write: assert property (ce && state_reg == RC_APPLY |=> chan_input_reg == $past(alu_result_reg))
        else $error("computed result not written to channel input");
    chk_index_mux: assert property (ce && lut_rd_en |=>
        $past(lut_addr) == to_index($past(sensor_override_enable) ? sensor_ovr_reg : sensor_result_reg))
        else $error("table index from wrong source");
    chk_sensor_pair: assert property (ce && level_two_reg && wr_hit(reg_req, ADDR_SENSOR_OVR_HIGH) && !wr_hit(reg_req, ADDR_SENSOR_OVR_LOW) |=> $stable(sensor_ovr_reg))
        else $error("sensor override changed before low write");
    chk_chan_pair: assert property (ce && level_two_reg && wr_hit(reg_req, ADDR_CHAN0_OVR_LOW) |=> chan_ovr_reg.ch0 == {$past(chan_ovr_high_pend_reg[0]), $past(reg_req.wdata)})
        else $error("channel override pair not committed together");
    chk_bypass_out: assert property (ce && arith_bypass_reg[0] && !input_override_enable |=> chan_analog_output.ch0 == $past(chan_base_reg.ch0))
        else $error("bypassed channel not at base value");
    chk_input_ovr: assert property (ce && input_override_enable |=> chan_analog_output == $past(chan_ovr_reg) ##1 1'b1)
        else $error("override words not routed to outputs");
    chk_access_grant: assert property (
        ce && wr_hit(reg_req, ADDR_ACCESS_LEVEL) && reg_req.wdata == PASSWORD_FIRST
        ##1 !(ce && wr_hit(reg_req, ADDR_ACCESS_LEVEL))
        ##1 ce && wr_hit(reg_req, ADDR_ACCESS_LEVEL) && reg_req.wdata == PASSWORD_SECOND |=> level_two_reg)
        else $error("password sequence did not grant level two");
    chk_access_read: assert property (ce && reg_req.rd && reg_req.addr == ADDR_ACCESS_LEVEL && level_two_reg |=> reg_rdata == ACCESS_READ_L2)
        else $error("access level read wrong");

    cov_recalc: cover property (state_reg == RC_IDLE && recalc_req ##1 state_reg == RC_FETCH ##1 state_reg == RC_APPLY);
    cov_sensor_ovr: cover property (ovr_commit ##1 state_reg == RC_FETCH);
    cov_input_ovr: cover property (level_two_reg && input_override_enable);

endmodule // tdac_mode_ctrl

//--- test/tdac_host_model.sv
// Host-side model that issues register writes and reads on the request port
module tdac_host_model
    import tdac_pkg::*;
(
    input wire logic sys_clk,
    output tdac_regreq_s reg_req,
    input wire logic [BYTE_W-1:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial reg_req = '0;
    // Bytes pass unaltered, so the word coding is what the caller chose
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_req <= '{1'b1, 1'b0, a, d};
        @(posedge sys_clk);
        reg_req <= '0;
    endtask
    // Data is taken one edge after the strobe is accepted, where it is settled
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge sys_clk);
        reg_req <= '0;
        @(posedge sys_clk);
        d = reg_rdata;
    endtask
endmodule // tdac_host_model

//--- test/test_temp_dac_signal_path_modes.sv
// Self-checking bench for the signal path mode control
module test_temp_dac_signal_path_modes
    import tdac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int T = 20;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [1:0] bp = 2'b00;
    logic lut_en = 1'b0;
    logic [3:0] lut_a = 4'h0;
    tdac_pair_s lut_d = '0, base_v = '0, nv_base = '0, out, e;
    tdac_word_t sample = 12'h123, ov, tab [2][16];
    tdac_regreq_s req;
    logic [7:0] rdata, d;
    logic [15:0] w;
    logic [31:0] tmp, seed = 32'h306c0f70;
    logic lvl, ce = 1'b1;
    int n_errors = 0, check_count = 0, cyc = 0;
    ////////////////////////////////////////////////////////////////////////////////
    tdac_mode_ctrl #(.SAMPLE_TICKS(T)) tdac_mode_ctrl_i (.sys_clk(sys_clk), .arst_n(arst_n), .ce(ce),
        .sensor_sample(sample), .nv_arith_bypass(bp), .nv_chan_base(nv_base), .lut_wr_en(lut_en),
        .lut_wr_addr(lut_a), .lut_wr_data(lut_d), .reg_req(req), .reg_rdata(rdata),
        .chan_analog_output(out), .level_two_access(lvl));
    tdac_host_model tdac_host_model_i (.sys_clk(sys_clk), .reg_req(req), .reg_rdata(rdata));
    initial forever #5 sys_clk = ~sys_clk;
    // Short sample period keeps the run small; the waits for a sample-driven recalculation are multiples of T
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic tdac_pair_s calc(input tdac_word_t idx);
        logic [3:0] a;
        a = {~idx[11], idx[10:8]};
        return '{base_v.ch1 + tab[1][a], base_v.ch0 + tab[0][a]};
    endfunction
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic rw(input logic [7:0] a, output logic [15:0] v);
        logic [7:0] h, l;
        tdac_host_model_i.rd(a, h);
        tdac_host_model_i.rd(a + 8'h01, l);
        v = {h, l};
    endtask
    task automatic pair(input logic [7:0] a, input tdac_word_t v);
        tdac_host_model_i.wr(a, {4'h0, v[11:8]});
        tdac_host_model_i.wr(a + 8'h01, v[7:0]);
    endtask
    task automatic rst(input logic [1:0] b);
        logic [31:0] r;
        arst_n <= 1'b0;
        bp <= b;
        r = rnd();
        base_v = r[23:0];
        nv_base <= r[23:0];
        repeat (20) @(posedge sys_clk);
        arst_n <= 1'b1;
        tick(3);
        if (b[0]) chk(out.ch0, base_v.ch0);
        for (int i = 0; i < 16; i++) begin
            r = rnd();
            tab[0][i] = r[11:0];
            tab[1][i] = r[23:12];
            @(posedge sys_clk);
            lut_en <= 1'b1;
            lut_a <= i[3:0];
            lut_d <= {tab[1][i], tab[0][i]};
        end
        @(posedge sys_clk);
        lut_en <= 1'b0;
    endtask
    task automatic wrap_up();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst(2'b01);
        tick(2 * T);
        e = calc(sample);
        chk(out, {e.ch1, base_v.ch0});
        tdac_host_model_i.rd(ADDR_OVERRIDE_CONTROL, d);
        chk(d, 8'h00);
        tdac_host_model_i.rd(ADDR_ACCESS_LEVEL, d);
        chk(d, ACCESS_READ_NONE);
        rst(2'b00);
        // Both ends of the two's complement range, then random samples
        for (int k = 0; k < 4; k++) begin
            tmp = rnd();
            sample <= (k == 0) ? 12'h800 : (k == 1) ? 12'h7ff : tmp[11:0];
            tick(2 * T);
            e = calc(sample);
            chk(out, e);
            rw(ADDR_RESULT_HIGH, w);
            chk(w, {4'h0, sample});
            rw(ADDR_CHAN0_HIGH, w);
            chk(w, {4'h0, e.ch0});
        end
        // Enable low: timer and outputs hold although the live sample moves
        ce <= 1'b0;
        sample <= ~sample;
        tick(3 * T);
        chk(out, e);
        ce <= 1'b1;
        tdac_host_model_i.wr(ADDR_ACCESS_LEVEL, PASSWORD_FIRST);
        tdac_host_model_i.wr(ADDR_ACCESS_LEVEL, PASSWORD_SECOND);
        tdac_host_model_i.rd(ADDR_ACCESS_LEVEL, d);
        chk({lvl, d}, {1'b1, ACCESS_READ_L2});
        tmp = rnd();
        ov = tmp[11:0];
        pair(ADDR_SENSOR_OVR_HIGH, ov);
        tdac_host_model_i.wr(ADDR_OVERRIDE_CONTROL, 8'h01);
        tick(2 * T);
        e = calc(ov);
        chk(out, e);
        rw(ADDR_RESULT_HIGH, w);
        chk(w, {4'h0, sample});
        tdac_host_model_i.wr(ADDR_SENSOR_OVR_HIGH, {4'h0, ~ov[11:8]});
        tick(2 * T);
        chk(out, e);
        ov[11:8] = ~ov[11:8];
        tdac_host_model_i.wr(ADDR_SENSOR_OVR_LOW, ov[7:0]);
        tick(8);
        chk(out, calc(ov));
        tdac_host_model_i.wr(ADDR_OVERRIDE_CONTROL, 8'h00);
        tick(2 * T);
        e = calc(sample);
        chk(out, e);
        tmp = rnd();
        pair(ADDR_CHAN0_OVR_HIGH, tmp[11:0]);
        pair(ADDR_CHAN1_OVR_HIGH, tmp[23:12]);
        tdac_host_model_i.wr(ADDR_OVERRIDE_CONTROL, 8'h02);
        tick(3);
        chk(out, tmp[23:0]);
        rw(ADDR_CHAN1_HIGH, w);
        chk(w, {4'h0, e.ch1});
        tdac_host_model_i.wr(ADDR_CHAN1_OVR_HIGH, {4'h0, ~tmp[23:20]});
        tick(3);
        chk(out, tmp[23:0]);
        tdac_host_model_i.wr(ADDR_CHAN1_OVR_LOW, tmp[19:12]);
        tick(1);
        chk(out, {~tmp[23:20], tmp[19:0]});
        wrap_up();
    end
endmodule // test_temp_dac_signal_path_modes
